/* File: tsc_assertions.sv */
// port checker for the touchscreen serial controller
`timescale 1ns/1ps
module tsc_chk (
	input logic clk_sys,
	input logic rst,
	input logic [31:0] addr,
	input logic wr,
	input logic rd,
	input logic [31:0] rdata,
	input logic converter_select_n,
	input logic converter_serial_clock,
	input logic pen_interrupt_n,
	input logic pen_interrupt_input,
	input logic pen_irq
);
	localparam logic [31:0] cmd_a = 32'h1E000000;
	localparam logic [31:0] res_a = 32'h1E000004;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_START: assert property (wr && addr == cmd_a && converter_select_n |=> !converter_select_n)
		else $error("no select after command");
	AST_SCLK_IDLE: assert property (converter_select_n |-> !converter_serial_clock)
		else $error("clock moves while deselected");
	AST_BUSY: assert property (wr && addr == cmd_a && converter_select_n ##2 rd && addr == res_a
		|=> !rdata[15]) else $error("ready during transfer");
	AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0) else $error("stale read data");
	AST_RD_FMT: assert property ($past(rd) && $past(addr) == res_a |-> rdata[31:16] == 16'h0
		&& rdata[13:12] == 2'h0) else $error("unused bits set");
	AST_PEN_LVL: assert property ($fell(pen_interrupt_n) |-> ##[1:4] pen_interrupt_input)
		else $error("pen level late");
	AST_IRQ_SET: assert property (pen_interrupt_input |-> ##[0:2] pen_irq) else $error("no irq");
	AST_IRQ_CLR: assert property (wr && addr == res_a && !pen_interrupt_input && pen_interrupt_n
		|=> !pen_irq) else $error("irq not cleared");
endmodule
bind tsc_touch_serial_controller tsc_chk chk_u (.*);

/* File: tsc_conv_model.sv */
// converter model: takes the command byte, returns a 12-bit result
`timescale 1ns/1ps
module tsc_conv_model (
	input wire converter_select_n,
	input wire converter_serial_clock,
	input wire converter_serial_in,
	output logic converter_serial_out = 1'b0,
	output logic [7:0] cmd
);
	int n = 0;
	logic [11:0] res;
	always @(posedge converter_select_n) n <= 0;
	always @(posedge converter_serial_clock)
	begin
		if (n < 8)
			cmd[7 - n] <= converter_serial_in;
		n <= (n == 23) ? 0 : n + 1;
	end
	// outside the result bits the line toggles, never a stale copy
	always @(negedge converter_serial_clock)
	begin
		res = cmd[6] ? 12'hA5C : 12'h3B1;
		converter_serial_out <= (n > 8 && n < 21) ? res[20 - n] : ~converter_serial_out;
	end
endmodule

/* File: tsc_defines.vh */
// register map, field positions and timing constants for the touchscreen serial controller
`ifndef TSC_DEFINES_VH
`define TSC_DEFINES_VH
`define TSC_ADDR_COMMAND 32'h1E000000
`define TSC_ADDR_RESULT 32'h1E000004
`define TSC_BIT_READY 15
`define TSC_BIT_PEN 14
`define TSC_BIT_START 7
`define TSC_COMMAND_RESET 8'h00
`define TSC_XFER_CLOCKS 5'h18
`define TSC_CMD_CLOCKS 5'h08
`define TSC_BUSY_CLOCKS 5'h01
`define TSC_RESULT_CLOCKS 5'h0C
`define TSC_DIV_DEFAULT 8
`endif

/* File: tsc_touch_serial_controller.v */
// touchscreen serial controller: register port and converter serial engine
`timescale 1ns/1ps
`include "tsc_defines.vh"
module tsc_touch_serial_controller #(
	parameter HALF_DIV = `TSC_DIV_DEFAULT
)(
	input wire clk_sys,
	input wire rst,
	input wire clk_en,
	input wire [31:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	output reg converter_select_n,
	output reg converter_serial_clock,
	output reg converter_serial_in,
	input wire converter_serial_out,
	input wire pen_interrupt_n,
	output reg pen_interrupt_input,
	output wire pen_irq
);
	localparam [2:0] PH_IDLE = 3'h0;
	localparam [2:0] PH_COMMAND = 3'h1;
	localparam [2:0] PH_BUSY = 3'h2;
	localparam [2:0] PH_RESULT = 3'h3;
	localparam [2:0] PH_TRAIL = 3'h4;
	localparam [4:0] CMD_LAST = `TSC_CMD_CLOCKS - 5'h01;
	localparam [4:0] RES_FIRST = `TSC_CMD_CLOCKS + `TSC_BUSY_CLOCKS;
	localparam [4:0] BUSY_LAST = RES_FIRST - 5'h01;
	localparam [4:0] RES_LAST = RES_FIRST + `TSC_RESULT_CLOCKS - 5'h01;
	localparam [4:0] XFER_LAST = `TSC_XFER_CLOCKS - 5'h01;
	localparam [7:0] DIV_LAST = HALF_DIV[7:0] - 8'h01;
	// bit 0 carries converter data, bit 1 the pen line, which idles high
	localparam [1:0] SYNC_IDLE = 2'h2;

	reg [7:0] touch_command;
	reg [11:0] result;
	reg [11:0] shift_in;
	reg [7:0] shift_out;
	reg [2:0] phase;
	reg [2:0] next_phase;
	reg pen_latch;
	reg [4:0] clk_count;
	reg [7:0] div;
	reg [31:0] next_rdata;

	wire [1:0] pin_raw;
	wire [1:0] sync_out;
	wire dout_sync;
	wire pen_down;
	wire busy;
	wire wr_cmd;
	wire wr_res;
	wire start;
	wire half_tick;
	wire rise;
	wire fall;
	wire sample_bit;
	wire load_result;
	wire last_clock;
	wire [31:0] result_word;
	genvar gi;

	assign pin_raw = {pen_interrupt_n, converter_serial_out};
	assign dout_sync = sync_out[0];
	assign pen_down = ~sync_out[1];
	assign busy = (phase != PH_IDLE);
	assign wr_cmd = wr && (addr == `TSC_ADDR_COMMAND);
	assign wr_res = wr && (addr == `TSC_ADDR_RESULT);
	// a command during a transfer is dropped, not queued
	assign start = wr_cmd && !busy;
	assign half_tick = (div == DIV_LAST);
	assign rise = busy && half_tick && !converter_serial_clock;
	assign fall = busy && half_tick && converter_serial_clock;
	assign sample_bit = rise && (phase == PH_RESULT);
	assign load_result = fall && (phase == PH_RESULT) && (clk_count == RES_LAST);
	assign last_clock = fall && (phase == PH_TRAIL) && (clk_count == XFER_LAST);
	assign result_word = {16'h0000, !busy, pen_down, 2'h0, result};
	assign pen_irq = pen_latch;

	// two flops per pin; only the second stage is read by logic
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_sync
			reg stage1;
			reg stage2;
			always @(posedge clk_sys)
			begin
				if (rst)
				begin
					stage1 <= SYNC_IDLE[gi];
					stage2 <= SYNC_IDLE[gi];
				end
				else if (clk_en)
				begin
					stage1 <= pin_raw[gi];
					stage2 <= stage1;
				end
			end
			assign sync_out[gi] = stage2;
		end
	endgenerate

	always @*
	begin
		next_phase = phase;
		case (phase)
			PH_IDLE:
			begin
				if (start)
					next_phase = PH_COMMAND;
			end
			PH_COMMAND:
			begin
				if (fall && clk_count == CMD_LAST)
					next_phase = PH_BUSY;
			end
			PH_BUSY:
			begin
				if (fall && clk_count == BUSY_LAST)
					next_phase = PH_RESULT;
			end
			PH_RESULT:
			begin
				if (load_result)
					next_phase = PH_TRAIL;
			end
			PH_TRAIL:
			begin
				if (last_clock)
					next_phase = PH_IDLE;
			end
			default:
				next_phase = PH_IDLE;
		endcase
	end

	always @(posedge clk_sys)
	begin
		if (rst)
			phase <= PH_IDLE;
		else if (clk_en)
			phase <= next_phase;
	end

	// divider restarts with each command so the first half period is whole
	always @(posedge clk_sys)
	begin
		if (rst)
			div <= 8'h00;
		else if (clk_en)
		begin
			if (start)
			begin
				div <= 8'h00;
			end
			else if (busy && half_tick)
			begin
				div <= 8'h00;
			end
			else if (busy)
			begin
				div <= div + 8'h01;
			end
		end
	end

	always @(posedge clk_sys)
	begin
		if (rst)
			clk_count <= 5'h00;
		else if (clk_en)
		begin
			if (start)
			begin
				clk_count <= 5'h00;
			end
			else if (fall)
			begin
				clk_count <= clk_count + 5'h01;
			end
		end
	end

	// serial clock idles low, so every transfer ends on a falling edge
	always @(posedge clk_sys)
	begin
		if (rst)
			converter_serial_clock <= 1'b0;
		else if (clk_en)
		begin
			if (rise)
			begin
				converter_serial_clock <= 1'b1;
			end
			else if (fall)
			begin
				converter_serial_clock <= 1'b0;
			end
		end
	end

	always @(posedge clk_sys)
	begin
		if (rst)
			shift_out <= 8'h00;
		else if (clk_en)
		begin
			if (start)
			begin
				shift_out <= {wdata[6:0], 1'h0};
			end
			else if (fall)
			begin
				shift_out <= {shift_out[6:0], 1'h0};
			end
		end
	end

	// first bit is set up with select, the rest change on falling edges
	always @(posedge clk_sys)
	begin
		if (rst)
			converter_serial_in <= 1'b0;
		else if (clk_en)
		begin
			if (start)
			begin
				converter_serial_in <= wdata[`TSC_BIT_START];
			end
			else if (last_clock)
			begin
				converter_serial_in <= 1'b0;
			end
			else if (fall)
			begin
				converter_serial_in <= shift_out[7];
			end
		end
	end

	// result bits enter at the bottom, so the first one ends at the top
	always @(posedge clk_sys)
	begin
		if (rst)
			shift_in <= 12'h000;
		else if (clk_en && sample_bit)
			shift_in <= {shift_in[10:0], dout_sync};
	end

	always @(posedge clk_sys)
	begin
		if (rst)
			result <= 12'h000;
		else if (clk_en && load_result)
			result <= shift_in;
	end

	// select follows the start bit so it spans the whole reading sequence
	always @(posedge clk_sys)
	begin
		if (rst)
			converter_select_n <= 1'b1;
		else if (clk_en)
		begin
			if (start)
			begin
				converter_select_n <= 1'b0;
			end
			else if (last_clock)
			begin
				converter_select_n <= ~touch_command[`TSC_BIT_START];
			end
		end
	end

	always @(posedge clk_sys)
	begin
		if (rst)
			touch_command <= `TSC_COMMAND_RESET;
		else if (clk_en && start)
			touch_command <= wdata[7:0];
	end

	// set wins over the acknowledge write while the pen is still down
	always @(posedge clk_sys)
	begin
		if (rst)
			pen_latch <= 1'b0;
		else if (clk_en)
		begin
			if (pen_down)
			begin
				pen_latch <= 1'b1;
			end
			else if (wr_res)
			begin
				pen_latch <= 1'b0;
			end
		end
	end

	always @(posedge clk_sys)
	begin
		if (rst)
			pen_interrupt_input <= 1'b0;
		else if (clk_en)
			pen_interrupt_input <= pen_down;
	end

	// unmapped reads and idle cycles return zero
	always @*
	begin
		next_rdata = 32'h00000000;
		if (rd)
		begin
			case (addr)
				`TSC_ADDR_COMMAND:
				begin
					next_rdata = {24'h000000, touch_command};
				end
				`TSC_ADDR_RESULT:
				begin
					next_rdata = result_word;
				end
				default:
				begin
					next_rdata = 32'h00000000;
				end
			endcase
		end
	end

	always @(posedge clk_sys)
	begin
		if (rst)
			rdata <= 32'h00000000;
		else if (clk_en)
			rdata <= next_rdata;
	end
endmodule

/* File: tsc_touch_serial_controller_tb.sv */
// testbench for the touchscreen serial controller
`timescale 1ns/1ps
module tsc_touch_serial_controller_tb;
	logic clk_sys = 0, rst = 1, wr = 0, rd = 0, pen_n = 1, sdo, sel_n, sclk, sdi, pen_in, irq;
	logic [31:0] addr = 0, wdata = 0, rdata, rv;
	logic [7:0] cmd;
	int err_count = 0, total_checks = 0, edges = 0;
	tsc_touch_serial_controller #(.HALF_DIV(4)) dut_u (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
		.addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .converter_select_n(sel_n),
		.converter_serial_clock(sclk), .converter_serial_in(sdi), .converter_serial_out(sdo),
		.pen_interrupt_n(pen_n), .pen_interrupt_input(pen_in), .pen_irq(irq));
	tsc_conv_model conv_u (.converter_select_n(sel_n), .converter_serial_clock(sclk),
		.converter_serial_in(sdi), .converter_serial_out(sdo), .cmd(cmd));
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge sclk) edges++;
	task chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask
	task wreg(input logic [31:0] a, d);
		@(posedge clk_sys) {addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge clk_sys) wr <= 0;
	endtask
	task rreg(input logic [31:0] a);
		@(posedge clk_sys) {addr, rd} <= {a, 1'b1};
		@(posedge clk_sys) rd <= 0;
		@(negedge clk_sys) rv = rdata;
	endtask
	task xfer(input logic [7:0] c, input logic [11:0] exp);
		wreg(32'h1E000000, {24'h0, c});
		edges = 0;
		rreg(32'h1E000004);
		chk(rv[15], 0);
		for (int i = 0; i < 300 && !rv[15]; i++) rreg(32'h1E000004);
		chk(edges, 24);
		chk(cmd, c);
		chk(rv[11:0], exp);
	endtask
	task end_sim;
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task reset_check;
		rreg(32'h1E000004);
		chk(rv & 32'hFFFFC000, 32'h8000);
		chk({sel_n, sclk, irq}, 4);
	endtask
	task settle;
		repeat (50) @(posedge clk_sys);
	endtask
	task pen_sequence;
		xfer(8'h9B, 12'h3B1);
		settle;
		xfer(8'hDB, 12'hA5C);
		chk(sel_n, 0);
		settle;
		xfer(8'h9B, 12'h3B1);
		settle;
		xfer(8'hD8, 12'hA5C);
		xfer(8'h58, 12'hA5C);
		chk(sel_n, 1);
	endtask
	task pen_check;
		@(posedge clk_sys) pen_n <= 0;
		wreg(32'h1E000004, 0);
		rreg(32'h1E000004);
		chk({rv[14], irq}, 3);
		chk(pen_in, 1);
		@(posedge clk_sys) pen_n <= 1;
		repeat (3) @(posedge clk_sys);
		rreg(32'h1E000004);
		chk({rv[14], irq}, 1);
		wreg(32'h1E000004, 0);
		rreg(32'h1E000004);
		chk({rv[14], irq}, 0);
	endtask
	initial
	begin
		repeat (20) @(posedge clk_sys);
		rst <= 0;
		reset_check;
		pen_sequence;
		pen_check;
		end_sim;
	end
	initial
	begin
		#200000;
		err_count++;
		end_sim;
	end
endmodule
